//--- include/i2c_abort_pkg.sv
// Constants, register map and carrier types for the master abort cause block.
// Assumes a 32-bit AHB-Lite bus with one slave and a master engine giving event pulses.
//
// Summary of operation
// - Master request while master function is off sets cause bit 11.
// - Ten-bit read request with restart generation off sets cause bit 10.
// - Start byte request with restart generation off sets cause bit 9.
// - Clearing bit 9 while its cause remains drops it one cycle, then sets it again.
// - High-speed request with restart generation off sets cause bit 8.
// - Acknowledged start byte sent as master sets cause bit 7.
// - Acknowledged high-speed master code sets cause bit 6.
// - General call followed by a queued read command sets cause bit 5.
// - General call acknowledged by no slave sets cause bit 4.
// - Cause bits are read-only; one means the abort scenario happened.
// - Reading either clear register clears the cause bits, bit 9 as above.
package i2c_abort_pkg;
   // ************************************************************
   // Register map, byte addresses
   // ************************************************************
   localparam int ADDR_WIDTH = 12;
   localparam logic [11:0] CONFIG_OFFSET = 12'h000;
   localparam logic [11:0] INT_STATUS_OFFSET = 12'h02c;
   localparam logic [11:0] INT_MASK_OFFSET = 12'h030;
   localparam logic [11:0] ALL_CLEAR_OFFSET = 12'h040;
   localparam logic [11:0] ABORT_CLEAR_OFFSET = 12'h054;
   localparam logic [11:0] CAUSE_OFFSET = 12'h080;

   // ************************************************************
   // Field positions and reset values
   // ************************************************************
   localparam int CFG_MASTER_EN = 0;
   localparam int CFG_TEN_BIT = 1;
   localparam int CFG_HIGH_SPEED = 2;
   localparam int CFG_RESTART_EN = 5;
   localparam int CFG_SELECT_A = 6;
   localparam int CFG_GC_START = 7;
   localparam logic [31:0] CONFIG_MASK = 32'h0000_00e7;
   localparam logic [31:0] CONFIG_RESET = 32'h0000_0021;
   localparam int INT_TX_ABORT = 0;
   localparam int CAUSE_GCALL_NOACK = 4;
   localparam int CAUSE_GCALL_READ = 5;
   localparam int CAUSE_HS_ACKED = 6;
   localparam int CAUSE_SBYTE_ACKED = 7;
   localparam int CAUSE_HS_NORESTART = 8;
   localparam int CAUSE_SBYTE_NORESTART = 9;
   localparam int CAUSE_TEN_BIT_READ = 10;
   localparam int CAUSE_MASTER_DIS = 11;
   localparam logic [31:0] CAUSE_RESET = 32'h0000_0000;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

   // ************************************************************
   // Bus encodings
   // ************************************************************
   localparam int HTRANS_ACTIVE_BIT = 1;
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   localparam logic HRESP_OKAY = 1'b0;

   // Pulses from the master engine, one cycle each
   typedef struct packed {
      logic master_request;
      logic request_is_read;
      logic start_byte_acked;
      logic high_speed_code_acked;
      logic general_call_read;
      logic general_call_unacked;
      logic other_abort;
   } master_events_t;

   // Whole state of the block
   typedef struct packed {
      logic [31:0] config_reg;
      logic int_status_reg;
      logic int_mask_reg;
      logic [31:0] cause_reg;
      logic recheck_reg;
      logic wr_pend_reg;
      logic [11:0] wr_addr_reg;
      logic [31:0] hrdata_reg;
      logic hreadyout_reg;
      logic hresp_reg;
      logic master_stop_reg;
      logic irq_reg;
   } abort_state_t;

   localparam abort_state_t STATE_RESET = '{config_reg: CONFIG_RESET, int_status_reg: 1'b0,
      int_mask_reg: 1'b0, cause_reg: CAUSE_RESET, recheck_reg: 1'b0, wr_pend_reg: 1'b0,
      wr_addr_reg: 12'h000, hrdata_reg: WORD_ZERO, hreadyout_reg: 1'b1, hresp_reg: HRESP_OKAY,
      master_stop_reg: 1'b0, irq_reg: 1'b0};
endpackage

//--- src/i2c_master_abort_causes.sv
// Master-side abort cause register with AHB-Lite slave, interrupt and stop pulse.
// Assumes synchronous event pulses from the master engine and a single-slave bus.
//
// The register addresses and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module i2c_master_abort_causes (
   input wire logic clock,
   input wire logic resetn,
   input wire logic hsel,
   input wire logic [i2c_abort_pkg::ADDR_WIDTH-1:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire i2c_abort_pkg::master_events_t events,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   output logic irq,
   output logic master_stop
);
   // ************************************************************
   // State
   // ************************************************************
   i2c_abort_pkg::abort_state_t state_reg;
   i2c_abort_pkg::abort_state_t state_next;
   logic take;
   logic clear_read;
   logic all_clear_read;
   logic sbyte_level;
   logic [31:0] set_vec;

   // Address match shared by write and read decode
   function automatic logic hit(input logic [11:0] addr, input logic [11:0] offset);
      hit = (addr == offset);
   endfunction

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb
   begin
      state_next = state_reg;
      state_next.master_stop_reg = 1'b0;
      state_next.wr_pend_reg = 1'b0;
      state_next.hreadyout_reg = 1'b1; // Zero wait states throughout
      state_next.hresp_reg = i2c_abort_pkg::HRESP_OKAY;
      clear_read = 1'b0;
      all_clear_read = 1'b0;
      set_vec = i2c_abort_pkg::WORD_ZERO;

      // Write data phase lands one cycle after the address phase
      if (state_reg.wr_pend_reg)
      begin
         if (hit(state_reg.wr_addr_reg, i2c_abort_pkg::CONFIG_OFFSET))
            state_next.config_reg = hwdata & i2c_abort_pkg::CONFIG_MASK;
         else if (hit(state_reg.wr_addr_reg, i2c_abort_pkg::INT_STATUS_OFFSET))
            state_next.int_status_reg = state_reg.int_status_reg & ~hwdata[i2c_abort_pkg::INT_TX_ABORT];
         else if (hit(state_reg.wr_addr_reg, i2c_abort_pkg::INT_MASK_OFFSET))
            state_next.int_mask_reg = hwdata[i2c_abort_pkg::INT_TX_ABORT];
      end

      // Address phase; reads see a write that lands this cycle
      take = hsel & hready & htrans[i2c_abort_pkg::HTRANS_ACTIVE_BIT] & (hsize == i2c_abort_pkg::HSIZE_WORD);
      if (take && hwrite)
      begin
         state_next.wr_pend_reg = 1'b1;
         state_next.wr_addr_reg = haddr;
      end
      if (take && !hwrite)
      begin
         all_clear_read = hit(haddr, i2c_abort_pkg::ALL_CLEAR_OFFSET);
         clear_read = all_clear_read | hit(haddr, i2c_abort_pkg::ABORT_CLEAR_OFFSET);
         if (hit(haddr, i2c_abort_pkg::CONFIG_OFFSET))
            state_next.hrdata_reg = state_next.config_reg;
         else if (hit(haddr, i2c_abort_pkg::INT_STATUS_OFFSET))
            state_next.hrdata_reg = {31'h0000_0000, state_next.int_status_reg};
         else if (hit(haddr, i2c_abort_pkg::INT_MASK_OFFSET))
            state_next.hrdata_reg = {31'h0000_0000, state_next.int_mask_reg};
         else if (hit(haddr, i2c_abort_pkg::CAUSE_OFFSET))
            state_next.hrdata_reg = state_reg.cause_reg;
         else
            state_next.hrdata_reg = i2c_abort_pkg::WORD_ZERO; // Clear ports and holes read zero
      end

      // Cause conditions come from the settled configuration
      sbyte_level = !state_reg.config_reg[i2c_abort_pkg::CFG_RESTART_EN] &
         state_reg.config_reg[i2c_abort_pkg::CFG_SELECT_A] & state_reg.config_reg[i2c_abort_pkg::CFG_GC_START];
      if (events.master_request)
      begin
         set_vec[i2c_abort_pkg::CAUSE_MASTER_DIS] = !state_reg.config_reg[i2c_abort_pkg::CFG_MASTER_EN];
         set_vec[i2c_abort_pkg::CAUSE_TEN_BIT_READ] = !state_reg.config_reg[i2c_abort_pkg::CFG_RESTART_EN] &
            state_reg.config_reg[i2c_abort_pkg::CFG_TEN_BIT] & events.request_is_read;
         set_vec[i2c_abort_pkg::CAUSE_SBYTE_NORESTART] = sbyte_level;
         set_vec[i2c_abort_pkg::CAUSE_HS_NORESTART] = !state_reg.config_reg[i2c_abort_pkg::CFG_RESTART_EN] &
            state_reg.config_reg[i2c_abort_pkg::CFG_HIGH_SPEED];
      end
      set_vec[i2c_abort_pkg::CAUSE_SBYTE_ACKED] = events.start_byte_acked;
      set_vec[i2c_abort_pkg::CAUSE_HS_ACKED] = events.high_speed_code_acked;
      set_vec[i2c_abort_pkg::CAUSE_GCALL_READ] = events.general_call_read;
      set_vec[i2c_abort_pkg::CAUSE_GCALL_NOACK] = events.general_call_unacked;

      // clear on read, new events win over the clear
      if (clear_read)
         state_next.cause_reg = i2c_abort_pkg::CAUSE_RESET;
      state_next.cause_reg = state_next.cause_reg | set_vec;
      // bit 9 returns one cycle later while its cause persists
      state_next.recheck_reg = clear_read & state_reg.cause_reg[i2c_abort_pkg::CAUSE_SBYTE_NORESTART] & sbyte_level;
      if (state_reg.recheck_reg && sbyte_level)
         state_next.cause_reg[i2c_abort_pkg::CAUSE_SBYTE_NORESTART] = 1'b1;

      // any new cause flags an abort and stops the master
      if (clear_read)
         state_next.int_status_reg = 1'b0;
      if ((|set_vec) || events.other_abort)
      begin
         state_next.int_status_reg = 1'b1;
         state_next.master_stop_reg = 1'b1;
      end
      state_next.irq_reg = state_next.int_status_reg & state_next.int_mask_reg;
   end

   // Single register for the whole state
   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
         state_reg <= i2c_abort_pkg::STATE_RESET;
      else
         state_reg <= state_next;
   end

   // Outputs straight from flip-flops
   assign hrdata = state_reg.hrdata_reg;
   assign hreadyout = state_reg.hreadyout_reg;
   assign hresp = state_reg.hresp_reg;
   assign irq = state_reg.irq_reg;
   assign master_stop = state_reg.master_stop_reg;

   // ************************************************************
   // Checks
   // ************************************************************
   // All checks share one clock and drop out while reset is low
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);

   a_master_dis_set: assert property (
      events.master_request && !state_reg.config_reg[i2c_abort_pkg::CFG_MASTER_EN]
      |=> state_reg.cause_reg[i2c_abort_pkg::CAUSE_MASTER_DIS])
      else $error("master disabled cause not set");

   a_master_dis_only: assert property (
      $rose(state_reg.cause_reg[i2c_abort_pkg::CAUSE_MASTER_DIS])
      |-> $past(events.master_request) && !$past(state_reg.config_reg[i2c_abort_pkg::CFG_MASTER_EN]))
      else $error("master disabled cause set without its request");

   a_ten_bit_read: assert property (
      events.master_request && events.request_is_read
      && !state_reg.config_reg[i2c_abort_pkg::CFG_RESTART_EN]
      && state_reg.config_reg[i2c_abort_pkg::CFG_TEN_BIT]
      |=> state_reg.cause_reg[i2c_abort_pkg::CAUSE_TEN_BIT_READ])
      else $error("ten-bit read cause not set");

   a_ten_bit_only: assert property (
      $rose(state_reg.cause_reg[i2c_abort_pkg::CAUSE_TEN_BIT_READ])
      |-> $past(events.master_request) && $past(events.request_is_read)
      && $past(state_reg.config_reg[i2c_abort_pkg::CFG_TEN_BIT])
      && !$past(state_reg.config_reg[i2c_abort_pkg::CFG_RESTART_EN]))
      else $error("ten-bit read cause set without its request");

   a_sbyte_set: assert property (
      events.master_request && sbyte_level
      |=> state_reg.cause_reg[i2c_abort_pkg::CAUSE_SBYTE_NORESTART] && master_stop)
      else $error("start byte cause not set");

   a_sbyte_only: assert property (
      $rose(state_reg.cause_reg[i2c_abort_pkg::CAUSE_SBYTE_NORESTART])
      |-> $past(state_reg.recheck_reg) || ($past(events.master_request) && $past(sbyte_level)))
      else $error("start byte cause set without its request");

   a_sbyte_recheck: assert property (
      clear_read && state_reg.cause_reg[i2c_abort_pkg::CAUSE_SBYTE_NORESTART] && sbyte_level
      && !events.master_request
      |=> !state_reg.cause_reg[i2c_abort_pkg::CAUSE_SBYTE_NORESTART]
      ##1 (state_reg.cause_reg[i2c_abort_pkg::CAUSE_SBYTE_NORESTART] || !$past(sbyte_level)))
      else $error("bit 9 did not return after one cycle");

   a_hs_norestart: assert property (
      events.master_request && !state_reg.config_reg[i2c_abort_pkg::CFG_RESTART_EN]
      && state_reg.config_reg[i2c_abort_pkg::CFG_HIGH_SPEED]
      |=> state_reg.cause_reg[i2c_abort_pkg::CAUSE_HS_NORESTART])
      else $error("high speed cause not set");

   a_hs_only: assert property (
      $rose(state_reg.cause_reg[i2c_abort_pkg::CAUSE_HS_NORESTART])
      |-> $past(events.master_request) && $past(state_reg.config_reg[i2c_abort_pkg::CFG_HIGH_SPEED])
      && !$past(state_reg.config_reg[i2c_abort_pkg::CFG_RESTART_EN]))
      else $error("high speed cause set without its request");

   a_sbyte_acked: assert property (
      $rose(state_reg.cause_reg[i2c_abort_pkg::CAUSE_SBYTE_ACKED]) |-> $past(events.start_byte_acked))
      else $error("start byte ack cause without event");

   a_hs_acked: assert property (
      events.high_speed_code_acked
      |=> state_reg.cause_reg[i2c_abort_pkg::CAUSE_HS_ACKED] && irq == state_reg.int_mask_reg)
      else $error("high speed ack cause not set");

   a_hs_ack_only: assert property (
      $rose(state_reg.cause_reg[i2c_abort_pkg::CAUSE_HS_ACKED]) |-> $past(events.high_speed_code_acked))
      else $error("high speed ack cause without event");

   a_gcall_read: assert property (
      events.general_call_read |=> state_reg.cause_reg[i2c_abort_pkg::CAUSE_GCALL_READ])
      else $error("general call read cause not set");

   a_gcall_read_only: assert property (
      $rose(state_reg.cause_reg[i2c_abort_pkg::CAUSE_GCALL_READ]) |-> $past(events.general_call_read))
      else $error("general call read cause without event");

   a_gcall_noack: assert property (
      events.general_call_unacked |=> state_reg.cause_reg[i2c_abort_pkg::CAUSE_GCALL_NOACK])
      else $error("general call nack cause not set");

   a_gcall_noack_only: assert property (
      $rose(state_reg.cause_reg[i2c_abort_pkg::CAUSE_GCALL_NOACK]) |-> $past(events.general_call_unacked))
      else $error("general call nack cause without event");

   a_cause_ro: assert property (
      state_reg.wr_pend_reg && state_reg.wr_addr_reg == i2c_abort_pkg::CAUSE_OFFSET && !clear_read
      && set_vec == i2c_abort_pkg::WORD_ZERO && !state_reg.recheck_reg
      |=> $stable(state_reg.cause_reg))
      else $error("cause register changed by a write");

   a_cause_sticky: assert property (
      !clear_read
      |=> (state_reg.cause_reg & $past(state_reg.cause_reg)) == $past(state_reg.cause_reg))
      else $error("cause bit fell without a clear read");

   a_reserved_zero: assert property (
      (state_reg.cause_reg >> (i2c_abort_pkg::CAUSE_MASTER_DIS + 1)) == i2c_abort_pkg::WORD_ZERO
      && state_reg.cause_reg[i2c_abort_pkg::CAUSE_GCALL_NOACK-1:0] == '0)
      else $error("cause bit outside this block set");

   a_cause_rdata: assert property (
      take && !hwrite && hit(haddr, i2c_abort_pkg::CAUSE_OFFSET)
      |=> hrdata == $past(state_reg.cause_reg))
      else $error("cause read returned wrong data");

   a_clear_read: assert property (
      clear_read && set_vec == i2c_abort_pkg::WORD_ZERO
      |=> (state_reg.cause_reg & ~(32'h1 << i2c_abort_pkg::CAUSE_SBYTE_NORESTART)) == i2c_abort_pkg::WORD_ZERO)
      else $error("cause bits survived a clear read");

   a_clear_status: assert property (
      clear_read && set_vec == i2c_abort_pkg::WORD_ZERO && !events.other_abort
      |=> !state_reg.int_status_reg)
      else $error("abort flag survived a clear read");

   a_clear_rdata: assert property (
      clear_read |=> hrdata == i2c_abort_pkg::WORD_ZERO)
      else $error("clear port returned nonzero data");

   a_abort_flag: assert property (
      set_vec != i2c_abort_pkg::WORD_ZERO
      |=> state_reg.int_status_reg && master_stop
      ##1 (!master_stop || set_vec != i2c_abort_pkg::WORD_ZERO || events.other_abort))
      else $error("abort flag or stop missing");

   a_stop_cause: assert property (
      master_stop |-> $past(set_vec != i2c_abort_pkg::WORD_ZERO) || $past(events.other_abort))
      else $error("stop pulse without an abort");

   a_irq_match: assert property (
      irq == (state_reg.int_status_reg & state_reg.int_mask_reg))
      else $error("interrupt differs from masked flag");

   a_status_w1c: assert property (
      state_reg.wr_pend_reg && state_reg.wr_addr_reg == i2c_abort_pkg::INT_STATUS_OFFSET
      && hwdata[i2c_abort_pkg::INT_TX_ABORT] && set_vec == i2c_abort_pkg::WORD_ZERO && !events.other_abort
      |=> !state_reg.int_status_reg)
      else $error("abort flag not cleared by writing one");
endmodule
`default_nettype wire

//--- tb/abort_event_source.sv
// Stand-in for the master engine and the I2C far side: one-cycle event pulses.
// Assumes every call starts just after a rising clock edge.
`timescale 1ns/10ps
`default_nettype none
module abort_event_source (
   input wire logic clock,
   output logic [6:0] events
);
   // Idle: no event pending
   initial events = 7'h00;
   // Pulse one event bit; bit 5 qualifies a master request as a read
   task automatic fire(input int unsigned bit_index, input logic is_read);
      logic [6:0] v;
      v = 7'h00;
      v[bit_index] = 1'b1;
      v[5] = is_read;
      events <= v;
      @(posedge clock);
      events <= 7'h00;
   endtask
endmodule
`default_nettype wire

//--- tb/tb_i2c_master_abort_causes.sv
// Self-checking bench for the master abort cause block over AHB-Lite.
// Assumes a zero-wait single slave; hready is fed back from hreadyout.
`timescale 1ns/10ps
`default_nettype none
module tb_i2c_master_abort_causes;
   logic clock, resetn, hsel, hwrite, hreadyout, hresp, irq, master_stop;
   logic [11:0] haddr;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] hwdata, hrdata, rd;
   logic [6:0] ev;
   int num_errors = 0;
   int num_checks = 0;
   int cycles = 0;

   i2c_master_abort_causes i2c_master_abort_causes_inst (.clock(clock), .resetn(resetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .events(ev), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .master_stop(master_stop));
   abort_event_source abort_event_source_inst (.clock(clock), .events(ev));

   // ************************************************************
   // Clock and hang guard
   // ************************************************************
   initial
   begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   // Tests need about 120 cycles; far beyond that is a hang
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         num_errors++;
         conclude();
      end
   end

   // ************************************************************
   // Bus tasks and checks
   // ************************************************************
   // Address phase held until hready, then data phase until hready
   task automatic bus_xfer(input logic [11:0] a, input logic wr, input logic [31:0] d, output logic [31:0] r);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= wr;
      hsize <= 3'h2;
      do @(posedge clock); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clock); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
         $display("mismatch at %0t: got %h expected %h (error %0d)", $time, got, exp, ++num_errors);
   endtask
   // One abort cause: raise it, see stop, flag and irq, clear by read
   task automatic cause_case(input logic [31:0] cfg, input int unsigned e, input logic is_read,
      input int unsigned pos, input logic [11:0] clr, input logic [31:0] after);
      bus_xfer(i2c_abort_pkg::CONFIG_OFFSET, 1'b1, cfg, rd);
      abort_event_source_inst.fire(e, is_read);
      #1 chk({31'h0, master_stop}, 32'h1);
      bus_xfer(i2c_abort_pkg::CAUSE_OFFSET, 1'b0, 32'h0, rd);
      chk(rd, 32'h1 << pos);
      chk({31'h0, irq}, 32'h1);
      bus_xfer(i2c_abort_pkg::INT_STATUS_OFFSET, 1'b0, 32'h0, rd);
      chk(rd, 32'h1);
      bus_xfer(clr, 1'b0, 32'h0, rd);
      chk(rd, 32'h0);
      bus_xfer(i2c_abort_pkg::CAUSE_OFFSET, 1'b0, 32'h0, rd);
      chk(rd, after);
      $display("test cause bit %0d done", pos);
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // ************************************************************
   // Test sequence
   // ************************************************************
   initial
   begin
      {resetn, hsel, hwrite, haddr, htrans, hwdata} = '0;
      hsize = 3'h2;
      repeat (5) @(posedge clock);
      resetn <= 1'b1;
      @(posedge clock);
      bus_xfer(i2c_abort_pkg::CONFIG_OFFSET, 1'b0, 32'h0, rd);
      chk(rd, i2c_abort_pkg::CONFIG_RESET);
      chk({31'h0, hresp}, {31'h0, i2c_abort_pkg::HRESP_OKAY});
      bus_xfer(i2c_abort_pkg::CAUSE_OFFSET, 1'b0, 32'h0, rd);
      chk(rd, i2c_abort_pkg::CAUSE_RESET);
      bus_xfer(i2c_abort_pkg::INT_MASK_OFFSET, 1'b1, 32'h1, rd);
      // Legal request: master on, restart on, no cause expected
      abort_event_source_inst.fire(6, 1'b0);
      #1 chk({31'h0, master_stop}, 32'h0);
      bus_xfer(i2c_abort_pkg::CAUSE_OFFSET, 1'b0, 32'h0, rd);
      chk(rd, 32'h0);
      $display("test reset and legal request done");
      cause_case(32'h20, 6, 1'b0, 11, i2c_abort_pkg::ALL_CLEAR_OFFSET, 32'h0);
      cause_case(32'h03, 6, 1'b1, 10, i2c_abort_pkg::ABORT_CLEAR_OFFSET, 32'h0);
      cause_case(32'h05, 6, 1'b0, 8, i2c_abort_pkg::ALL_CLEAR_OFFSET, 32'h0);
      cause_case(32'hc1, 6, 1'b0, 9, i2c_abort_pkg::ABORT_CLEAR_OFFSET, 32'h200);
      // Cause removed by enabling restart, then bit 9 clears normally
      bus_xfer(i2c_abort_pkg::CONFIG_OFFSET, 1'b1, 32'h21, rd);
      bus_xfer(i2c_abort_pkg::ALL_CLEAR_OFFSET, 1'b0, 32'h0, rd);
      bus_xfer(i2c_abort_pkg::CAUSE_OFFSET, 1'b0, 32'h0, rd);
      chk(rd, 32'h0);
      cause_case(32'h21, 4, 1'b0, 7, i2c_abort_pkg::ALL_CLEAR_OFFSET, 32'h0);
      cause_case(32'h21, 3, 1'b0, 6, i2c_abort_pkg::ABORT_CLEAR_OFFSET, 32'h0);
      cause_case(32'h21, 2, 1'b0, 5, i2c_abort_pkg::ALL_CLEAR_OFFSET, 32'h0);
      cause_case(32'h21, 1, 1'b0, 4, i2c_abort_pkg::ABORT_CLEAR_OFFSET, 32'h0);
      // Cause register ignores writes; unmapped place reads zero
      bus_xfer(i2c_abort_pkg::CAUSE_OFFSET, 1'b1, 32'hffff_fff0, rd);
      bus_xfer(i2c_abort_pkg::CAUSE_OFFSET, 1'b0, 32'h0, rd);
      chk(rd, 32'h0);
      bus_xfer(12'h0f0, 1'b0, 32'h0, rd);
      chk(rd, 32'h0);
      // Abort without a cause bit: flag set, then cleared by writing one
      abort_event_source_inst.fire(0, 1'b0);
      bus_xfer(i2c_abort_pkg::INT_STATUS_OFFSET, 1'b0, 32'h0, rd);
      chk(rd, 32'h1);
      bus_xfer(i2c_abort_pkg::INT_STATUS_OFFSET, 1'b1, 32'h1, rd);
      bus_xfer(i2c_abort_pkg::INT_STATUS_OFFSET, 1'b0, 32'h0, rd);
      chk(rd, 32'h0);
      #1 chk({31'h0, irq}, 32'h0);
      $display("test read-only and flag clear done");
      conclude();
   end
endmodule
`default_nettype wire
